// ===== cso_clock_source_control.sv
// Function
// - debug_run_select at D1 resets 0; 0 stops peripheral clock in debug, 1 runs.
// - prescaler_run at D0 resets 0; writing 1 starts prescalers, 0 stops them.
// - fast_clock_source_select at D1: 1 fast external, 0 internal (reset).
// - fast clock select writes ignored unless internal and fast external both run.
// - system_clock_source_select at D0: 1 low-speed oscillator, 0 high-speed (reset).
// - system select writes ignored unless low-speed and high-speed clocks both run.
// - system switch takes at least one high-speed, at most one low-speed cycle.
// - the oscillator sourcing the system clock keeps running despite enable cleared.
// - leaving halt or sleep restores the clock configuration held before.
// - internal settle field D7-6: 3=8, 2=16, 1=32, 0=64 cycles; resets 0.
// - internal oscillator clock withheld until its settle count elapses.
// - after reset wait is 64 cycles; CPU starts after start and settle.
// - fast external settle field D5-4: 3=128 ... 0=1024 cycles; resets 0.
// - fast external clock withheld until its settle count elapses, also on software start.
// - internal_osc_enable at D2 turns internal oscillator on; resets 1.
// - low_speed_osc_enable D1 and fast_external_osc_enable D0 turn on; reset 0.
// - low-speed clock withheld for 256 of its cycles after enabling.
`timescale 1ns/1ps
`default_nettype none
module cso_clock_source_control
  import cso_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // register port
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // core state
  input wire logic debug_mode_in,
  input wire logic low_power_in,
  // oscillator clocks seen as pins: internal, fast external, low-speed
  input wire logic internal_osc_clk_in,
  input wire logic fast_external_osc_clk_in,
  input wire logic low_speed_osc_clk_in,
  // oscillator control and status
  output logic internal_osc_on_out,
  output logic fast_external_osc_on_out,
  output logic low_speed_osc_on_out,
  output logic internal_osc_ready_out,
  output logic fast_external_osc_ready_out,
  output logic low_speed_osc_ready_out,
  // clock multiplexer selects and gating
  output logic high_speed_clock_select_out,
  output logic system_clock_select_out,
  output logic prescaler_enable_out,
  output logic cpu_start_out
);

  // register bits
  logic debug_run_select;
  logic prescaler_run;
  logic fast_clock_source_select;
  logic system_clock_source_select;
  logic [1:0] internal_osc_settle_select;
  logic [1:0] fast_external_settle_select;
  logic internal_osc_enable;
  logic low_speed_osc_enable;
  logic fast_external_osc_enable;
  logic cpu_started;
  logic hs_mux;
  logic sys_mux;

  // per-oscillator sync, counters and status
  logic [CSO_OSC_COUNT-1:0] osc_pin;
  logic [CSO_OSC_COUNT-1:0] osc_meta;
  logic [CSO_OSC_COUNT-1:0] osc_sync;
  logic [CSO_OSC_COUNT-1:0] osc_last;
  logic [CSO_OSC_COUNT-1:0] osc_rise;
  logic [CSO_OSC_COUNT-1:0] osc_on;
  logic [CSO_OSC_COUNT-1:0] osc_ready;
  logic [CSO_SETTLE_W-1:0] settle_cnt [CSO_OSC_COUNT];
  logic [CSO_SETTLE_W-1:0] settle_target [CSO_OSC_COUNT];

  // address decode
  wire sel_psc = (reg_addr_in == CSO_ADDR_PRESCALER_CONTROL);
  wire sel_src = (reg_addr_in == CSO_ADDR_CLOCK_SOURCE_SELECT);
  wire sel_ctl = (reg_addr_in == CSO_ADDR_OSCILLATION_CONTROL);
  wire wr_psc = reg_wr_in && sel_psc;
  wire wr_src = reg_wr_in && sel_src;
  wire wr_ctl = reg_wr_in && sel_ctl;

  // settle targets from the wait fields
  assign settle_target[CSO_OSC_INTERNAL] =
    (internal_osc_settle_select == 2'h3) ? CSO_INTERNAL_SETTLE_3 :
    (internal_osc_settle_select == 2'h2) ? CSO_INTERNAL_SETTLE_2 :
    (internal_osc_settle_select == 2'h1) ? CSO_INTERNAL_SETTLE_1 : CSO_INTERNAL_SETTLE_0;
  assign settle_target[CSO_OSC_FAST_EXTERNAL] =
    (fast_external_settle_select == 2'h3) ? CSO_FAST_SETTLE_3 :
    (fast_external_settle_select == 2'h2) ? CSO_FAST_SETTLE_2 :
    (fast_external_settle_select == 2'h1) ? CSO_FAST_SETTLE_1 : CSO_FAST_SETTLE_0;
  assign settle_target[CSO_OSC_LOW_SPEED] = CSO_LOW_SPEED_SETTLE;

  // which oscillator carries the system clock, before or after a pending switch
  wire use_internal = (!system_clock_source_select && !fast_clock_source_select) ||
                      (!sys_mux && !hs_mux);
  wire use_fast = (!system_clock_source_select && fast_clock_source_select) ||
                  (!sys_mux && hs_mux);
  wire use_low = system_clock_source_select || sys_mux;

  // enables: the active source is never stopped; low power stops the rest
  assign osc_on[CSO_OSC_INTERNAL] = use_internal || (internal_osc_enable && !low_power_in);
  assign osc_on[CSO_OSC_FAST_EXTERNAL] =
    use_fast || (fast_external_osc_enable && !low_power_in);
  assign osc_on[CSO_OSC_LOW_SPEED] = use_low || (low_speed_osc_enable && !low_power_in);
  assign osc_pin = {low_speed_osc_clk_in, fast_external_osc_clk_in, internal_osc_clk_in};
  assign osc_rise = osc_sync & ~osc_last;

  // per-oscillator synchroniser and stabilisation counter
  genvar gi;
  generate
    for (gi = 0; gi < CSO_OSC_COUNT; gi++) begin : g_osc
      always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
          osc_meta[gi] <= 1'h0;
          osc_sync[gi] <= 1'h0;
          osc_last[gi] <= 1'h0;
        end else begin
          osc_meta[gi] <= osc_pin[gi];
          osc_sync[gi] <= osc_meta[gi];
          osc_last[gi] <= osc_sync[gi];
        end
      end
      // count oscillator edges from start; restart whenever it is stopped
      always_ff @(posedge sys_clk_in) begin
        if (!nrst_in || !osc_on[gi]) begin
          settle_cnt[gi] <= CSO_SETTLE_RESET;
        end else if (osc_rise[gi] && settle_cnt[gi] < settle_target[gi]) begin
          settle_cnt[gi] <= settle_cnt[gi] + 11'h001;
        end
      end
      assign osc_ready[gi] = osc_on[gi] && (settle_cnt[gi] >= settle_target[gi]);
    end
  endgenerate

  // switch permission
  wire hs_ready = hs_mux ? osc_ready[CSO_OSC_FAST_EXTERNAL] : osc_ready[CSO_OSC_INTERNAL];
  wire hs_allow = osc_ready[CSO_OSC_INTERNAL] && osc_ready[CSO_OSC_FAST_EXTERNAL];
  wire sys_allow = osc_ready[CSO_OSC_LOW_SPEED] && hs_ready;
  wire next_fast_sel = (wr_src && hs_allow) ?
    reg_wdata_in[CSO_BIT_FAST_CLOCK_SOURCE_SELECT] : fast_clock_source_select;
  wire next_sys_sel = (wr_src && sys_allow) ?
    reg_wdata_in[CSO_BIT_SYSTEM_CLOCK_SOURCE_SELECT] : system_clock_source_select;

  // register writes; low power leaves them untouched
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      debug_run_select <= CSO_RST_DEBUG_RUN_SELECT;
      prescaler_run <= CSO_RST_PRESCALER_RUN;
      fast_clock_source_select <= CSO_RST_FAST_CLOCK_SOURCE_SELECT;
      system_clock_source_select <= CSO_RST_SYSTEM_CLOCK_SOURCE_SELECT;
      internal_osc_settle_select <= CSO_RST_INTERNAL_OSC_SETTLE;
      fast_external_settle_select <= CSO_RST_FAST_EXTERNAL_SETTLE;
      internal_osc_enable <= CSO_RST_INTERNAL_OSC_ENABLE;
      low_speed_osc_enable <= CSO_RST_LOW_SPEED_OSC_ENABLE;
      fast_external_osc_enable <= CSO_RST_FAST_EXTERNAL_OSC_ENABLE;
    end else begin
      fast_clock_source_select <= next_fast_sel;
      system_clock_source_select <= next_sys_sel;
      if (wr_psc) begin
        debug_run_select <= reg_wdata_in[CSO_BIT_DEBUG_RUN_SELECT];
        prescaler_run <= reg_wdata_in[CSO_BIT_PRESCALER_RUN];
      end
      if (wr_ctl) begin
        internal_osc_settle_select <= reg_wdata_in[CSO_POS_INTERNAL_OSC_SETTLE +: 2];
        fast_external_settle_select <= reg_wdata_in[CSO_POS_FAST_EXTERNAL_SETTLE +: 2];
        internal_osc_enable <= reg_wdata_in[CSO_BIT_INTERNAL_OSC_ENABLE];
        low_speed_osc_enable <= reg_wdata_in[CSO_BIT_LOW_SPEED_OSC_ENABLE];
        fast_external_osc_enable <= reg_wdata_in[CSO_BIT_FAST_EXTERNAL_OSC_ENABLE];
      end
    end
  end

  // mux handover only on a rising edge: of the newly selected high-speed source for hs_mux, of the low-speed clock for sys_mux
  wire hs_switch_edge = fast_clock_source_select ? osc_rise[CSO_OSC_FAST_EXTERNAL] :
                        osc_rise[CSO_OSC_INTERNAL];
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      hs_mux <= CSO_RST_FAST_CLOCK_SOURCE_SELECT;
      sys_mux <= CSO_RST_SYSTEM_CLOCK_SOURCE_SELECT;
    end else begin
      if (hs_switch_edge) begin
        hs_mux <= fast_clock_source_select;
      end
      if (osc_rise[CSO_OSC_LOW_SPEED]) begin
        sys_mux <= system_clock_source_select;
      end
    end
  end

  // cpu start latch after the first internal settle
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cpu_started <= 1'h0;
    end else if (osc_ready[CSO_OSC_INTERNAL]) begin
      cpu_started <= 1'h1;
    end
  end

  // read data mux, one cycle after the strobe
  wire [7:0] rd_psc = {6'h00, debug_run_select, prescaler_run};
  wire [7:0] rd_src = {6'h00, fast_clock_source_select, system_clock_source_select};
  wire [7:0] rd_ctl = {internal_osc_settle_select, fast_external_settle_select, 1'h0,
                       internal_osc_enable, low_speed_osc_enable, fast_external_osc_enable};
  wire [7:0] rd_mux = sel_psc ? rd_psc : sel_src ? rd_src : sel_ctl ? rd_ctl : 8'h00;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // outputs
  assign internal_osc_on_out = osc_on[CSO_OSC_INTERNAL];
  assign fast_external_osc_on_out = osc_on[CSO_OSC_FAST_EXTERNAL];
  assign low_speed_osc_on_out = osc_on[CSO_OSC_LOW_SPEED];
  assign internal_osc_ready_out = osc_ready[CSO_OSC_INTERNAL];
  assign fast_external_osc_ready_out = osc_ready[CSO_OSC_FAST_EXTERNAL];
  assign low_speed_osc_ready_out = osc_ready[CSO_OSC_LOW_SPEED];
  assign high_speed_clock_select_out = hs_mux;
  assign system_clock_select_out = sys_mux;
  assign prescaler_enable_out = prescaler_run && (debug_run_select || !debug_mode_in);
  assign cpu_start_out = cpu_started;

  // checks
  property p_prescaler_gate;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $past(wr_psc) && debug_mode_in |->
      prescaler_enable_out == ($past(reg_wdata_in[1]) && $past(reg_wdata_in[0]));
  endproperty
  a_prescaler_gate: assert property (p_prescaler_gate) else $error("prescaler gate wrong");

  property p_prescaler_run;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_psc && !debug_mode_in ##1 !debug_mode_in |-> prescaler_enable_out == $past(reg_wdata_in[0]);
  endproperty
  a_prescaler_run: assert property (p_prescaler_run) else $error("prescaler run wrong");

  property p_hs_refused;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_src && !hs_allow |=> $stable(fast_clock_source_select);
  endproperty
  a_hs_refused: assert property (p_hs_refused) else $error("fast select changed while refused");

  property p_sys_refused;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_src && !sys_allow |=> $stable(system_clock_source_select);
  endproperty
  a_sys_refused: assert property (p_sys_refused) else $error("system select changed while refused");

  property p_sys_switch_edge;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $changed(sys_mux) |-> $past(osc_rise[CSO_OSC_LOW_SPEED]) && $past(system_clock_source_select) == sys_mux;
  endproperty
  a_sys_switch_edge: assert property (p_sys_switch_edge) else $error("system switch off edge");

  property p_active_kept;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (!sys_mux && !hs_mux |-> osc_on[CSO_OSC_INTERNAL]) and
    (!sys_mux && hs_mux |-> osc_on[CSO_OSC_FAST_EXTERNAL]) and
    (sys_mux |-> osc_on[CSO_OSC_LOW_SPEED]);
  endproperty
  a_active_kept: assert property (p_active_kept) else $error("active oscillator stopped");

  property p_internal_settle;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(osc_ready[CSO_OSC_INTERNAL]) |-> settle_cnt[CSO_OSC_INTERNAL] ==
      (4'h8 << (2'h3 - internal_osc_settle_select));
  endproperty
  a_internal_settle: assert property (p_internal_settle) else $error("internal settle count wrong");

  property p_fast_settle;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    osc_ready[CSO_OSC_FAST_EXTERNAL] |->
      settle_cnt[CSO_OSC_FAST_EXTERNAL] >= (11'h080 << (2'h3 - fast_external_settle_select));
  endproperty
  a_fast_settle: assert property (p_fast_settle) else $error("fast external released early");

  property p_low_settle;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    osc_ready[CSO_OSC_LOW_SPEED] |-> settle_cnt[CSO_OSC_LOW_SPEED] == 11'h100;
  endproperty
  a_low_settle: assert property (p_low_settle) else $error("low-speed released early");

  property p_reset_values;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $past(!nrst_in) |-> internal_osc_enable && !low_speed_osc_enable && !cpu_started &&
      !fast_external_osc_enable && !prescaler_run && internal_osc_settle_select == 2'h0;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

  property p_cpu_start;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(cpu_started) |-> $past(osc_ready[CSO_OSC_INTERNAL]);
  endproperty
  a_cpu_start: assert property (p_cpu_start) else $error("cpu started before settle");

  property p_low_power_keeps;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $fell(low_power_in) |-> $stable(system_clock_source_select) && $stable(fast_clock_source_select);
  endproperty
  a_low_power_keeps: assert property (p_low_power_keeps) else $error("wake changed sources");

  c_sys_to_low: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $rose(sys_mux));
  c_hs_to_fast: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $rose(hs_mux));
  property p_hs_switch_edge;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $changed(hs_mux) |-> $past(hs_switch_edge) && $past(fast_clock_source_select) == hs_mux;
  endproperty
  a_hs_switch_edge: assert property (p_hs_switch_edge) else $error("fast switch off edge");

  property p_sys_needs_ready;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(system_clock_source_select) |->
      $past(osc_ready[CSO_OSC_LOW_SPEED]) && $past(hs_ready);
  endproperty
  a_sys_needs_ready: assert property (p_sys_needs_ready) else $error("select not ready");

  // a stopped oscillator must settle again from zero
  property p_fast_restart;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    !osc_on[CSO_OSC_FAST_EXTERNAL] |=> !osc_ready[CSO_OSC_FAST_EXTERNAL];
  endproperty
  a_fast_restart: assert property (p_fast_restart) else $error("fast ready while off");

  property p_internal_restart;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    !osc_on[CSO_OSC_INTERNAL] |=> !osc_ready[CSO_OSC_INTERNAL];
  endproperty
  a_internal_restart: assert property (p_internal_restart) else $error("internal ready while off");

  c_refused: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) wr_src && !sys_allow);
  c_fast_ready: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(osc_ready[CSO_OSC_FAST_EXTERNAL]));
  c_wake: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $fell(low_power_in));

endmodule : cso_clock_source_control
`default_nettype wire

// ===== cso_clock_source_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cso_clock_source_control_bench
  import cso_pkg::*;
;
  typedef struct {
    logic [15:0] a;
    logic [7:0] d;
    logic dbg;
    logic [7:0] rd;
    logic pen;
  } cso_row_type;
  // ordinary register cases: write, debug level, expected read and prescaler enable
  cso_row_type rows [8] = '{
    '{16'h4020, 8'hFF, 1'b0, 8'h03, 1'b1},
    '{16'h4020, 8'h01, 1'b1, 8'h01, 1'b0},
    '{16'h4020, 8'h03, 1'b1, 8'h03, 1'b1},
    '{16'h4020, 8'h00, 1'b0, 8'h00, 1'b0},
    '{16'h5061, 8'h44, 1'b0, 8'h44, 1'b0},
    '{16'h5061, 8'h84, 1'b0, 8'h84, 1'b0},
    '{16'h5061, 8'hFC, 1'b0, 8'hF4, 1'b0},
    '{16'h5062, 8'hFF, 1'b0, 8'h00, 1'b0}
  };
  int half_p [3] = '{2, 2, 3};
  int edges [3] = '{0, 0, 0};
  int div [3] = '{0, 0, 0};
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dbg = 1'b0;
  logic lp = 1'b0;
  logic [2:0] pin = 3'h0;
  logic [7:0] rdata;
  logic [2:0] on_vec;
  logic [2:0] rdy_vec;
  logic hs_sel;
  logic sys_sel;
  logic pen;
  logic cpu_go;

  always #20 sys_clk = ~sys_clk;

  cso_clock_source_control dut (
    .sys_clk_in(sys_clk), .nrst_in(nrst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .debug_mode_in(dbg), .low_power_in(lp),
    .internal_osc_clk_in(pin[0]), .fast_external_osc_clk_in(pin[1]),
    .low_speed_osc_clk_in(pin[2]),
    .internal_osc_on_out(on_vec[0]), .fast_external_osc_on_out(on_vec[1]),
    .low_speed_osc_on_out(on_vec[2]), .internal_osc_ready_out(rdy_vec[0]),
    .fast_external_osc_ready_out(rdy_vec[1]), .low_speed_osc_ready_out(rdy_vec[2]),
    .high_speed_clock_select_out(hs_sel), .system_clock_select_out(sys_sel),
    .prescaler_enable_out(pen), .cpu_start_out(cpu_go)
  );

  // oscillator models: pins stand low while off or in reset, edges counted from start
  always @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!nrst || on_vec[i] !== 1'b1) begin
        div[i] <= 0;
        pin[i] <= 1'b0;
        edges[i] <= 0;
      end else if (div[i] == half_p[i] - 1) begin
        div[i] <= 0;
        pin[i] <= ~pin[i];
        if (!pin[i]) edges[i] <= edges[i] + 1;
      end else begin
        div[i] <= div[i] + 1;
      end
    end
  end

  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check_data(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_data

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_flag

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [15:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    check_data({8'h00, rdata}, {8'h00, exp});
    @(posedge sys_clk);
  endtask : reg_read

  // waits at falling edges for a ready flag, then checks the edge count seen
  task automatic wait_ready(input int i, input int exp);
    int k;
    k = 0;
    while (rdy_vec[i] !== 1'b1 && k < 6000) begin
      @(negedge sys_clk);
      k++;
    end
    check_data(16'(edges[i]), 16'(exp));
  endtask : wait_ready

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    @(posedge sys_clk);
    @(negedge sys_clk);
    check_data({8'h00, rdata}, 16'h0000);
    check_data({13'h0000, on_vec}, 16'h0001);
    check_flag(cpu_go, 1'b0);
    check_flag(hs_sel, 1'b0);
    check_flag(sys_sel, 1'b0);
    @(posedge sys_clk);
    nrst <= 1'b1;
    wait_ready(0, 64);
    check_flag(cpu_go, 1'b0);
    @(negedge sys_clk);
    check_flag(cpu_go, 1'b1);
    @(posedge sys_clk);
    reg_read(16'h4020, 8'h00);
    reg_read(16'h5060, 8'h00);
    reg_read(16'h5061, 8'h04);
    @(negedge sys_clk);
    check_data({8'h00, rdata}, 16'h0000);
    @(posedge sys_clk);
    for (int r = 0; r < 8; r++) begin
      reg_write(rows[r].a, rows[r].d);
      dbg <= rows[r].dbg;
      reg_read(rows[r].a, rows[r].rd);
      check_flag(pen, rows[r].pen);
    end
    // fast select refused while the fast oscillator is off
    reg_write(16'h5060, 8'h02);
    @(posedge sys_clk);
    reg_read(16'h5060, 8'h00);
    check_flag(hs_sel, 1'b0);
    for (int f = 0; f < 4; f++) begin
      reg_write(16'h5061, {2'h3, f[1:0], 4'h5});
      wait_ready(1, 128 << (3 - f));
      @(posedge sys_clk);
      if (f < 3) begin
        reg_write(16'h5061, 8'hC4);
        @(negedge sys_clk);
        check_flag(rdy_vec[1], 1'b0);
        @(posedge sys_clk);
      end
    end
    reg_write(16'h5060, 8'h02);
    @(posedge sys_clk);
    reg_read(16'h5060, 8'h02);
    repeat (12) begin
      @(negedge sys_clk);
      if (hs_sel === 1'b1) break;
    end
    check_flag(hs_sel, 1'b1);
    @(posedge sys_clk);
    // system select refused while the low-speed oscillator is off
    reg_write(16'h5060, 8'h03);
    @(posedge sys_clk);
    reg_read(16'h5060, 8'h02);
    reg_write(16'h5061, 8'hF7);
    wait_ready(2, 256);
    @(posedge sys_clk);
    reg_write(16'h5060, 8'h03);
    @(negedge sys_clk);
    check_flag(sys_sel, 1'b0);
    repeat (14) begin
      @(negedge sys_clk);
      if (sys_sel === 1'b1) break;
    end
    check_flag(sys_sel, 1'b1);
    @(posedge sys_clk);
    reg_read(16'h5060, 8'h03);
    // halt keeps only the system source running, wake restores all
    lp <= 1'b1;
    @(negedge sys_clk);
    check_flag(on_vec[0], 1'b0);
    check_flag(on_vec[2], 1'b1);
    @(posedge sys_clk);
    lp <= 1'b0;
    reg_read(16'h5061, 8'hF7);
    reg_read(16'h5060, 8'h03);
    check_data({13'h0000, on_vec}, 16'h0007);
    // clearing every enable leaves the system source running
    reg_write(16'h5061, 8'hF0);
    @(negedge sys_clk);
    check_flag(on_vec[2], 1'b1);
    check_flag(rdy_vec[2], 1'b1);
    check_flag(on_vec[0], 1'b0);
    @(posedge sys_clk);
    reg_read(16'h5061, 8'hF0);
    finish_test();
  end
endmodule : cso_clock_source_control_bench
`default_nettype wire

// ===== cso_pkg.sv
`default_nettype none
package cso_pkg;
  // register byte addresses
  localparam logic [15:0] CSO_ADDR_PRESCALER_CONTROL = 16'h4020;
  localparam logic [15:0] CSO_ADDR_CLOCK_SOURCE_SELECT = 16'h5060;
  localparam logic [15:0] CSO_ADDR_OSCILLATION_CONTROL = 16'h5061;
  // prescaler_control fields
  localparam int CSO_BIT_DEBUG_RUN_SELECT = 1;
  localparam int CSO_BIT_PRESCALER_RUN = 0;
  localparam logic CSO_RST_DEBUG_RUN_SELECT = 1'h0;
  localparam logic CSO_RST_PRESCALER_RUN = 1'h0;
  // clock_source_select fields
  localparam int CSO_BIT_FAST_CLOCK_SOURCE_SELECT = 1;
  localparam int CSO_BIT_SYSTEM_CLOCK_SOURCE_SELECT = 0;
  localparam logic CSO_RST_FAST_CLOCK_SOURCE_SELECT = 1'h0;
  localparam logic CSO_RST_SYSTEM_CLOCK_SOURCE_SELECT = 1'h0;
  // oscillation_control fields
  localparam int CSO_POS_INTERNAL_OSC_SETTLE = 6;
  localparam int CSO_POS_FAST_EXTERNAL_SETTLE = 4;
  localparam int CSO_BIT_INTERNAL_OSC_ENABLE = 2;
  localparam int CSO_BIT_LOW_SPEED_OSC_ENABLE = 1;
  localparam int CSO_BIT_FAST_EXTERNAL_OSC_ENABLE = 0;
  localparam logic [1:0] CSO_RST_INTERNAL_OSC_SETTLE = 2'h0;
  localparam logic [1:0] CSO_RST_FAST_EXTERNAL_SETTLE = 2'h0;
  localparam logic CSO_RST_INTERNAL_OSC_ENABLE = 1'h1;
  localparam logic CSO_RST_LOW_SPEED_OSC_ENABLE = 1'h0;
  localparam logic CSO_RST_FAST_EXTERNAL_OSC_ENABLE = 1'h0;
  // oscillator indices
  localparam int CSO_OSC_INTERNAL = 0;
  localparam int CSO_OSC_FAST_EXTERNAL = 1;
  localparam int CSO_OSC_LOW_SPEED = 2;
  localparam int CSO_OSC_COUNT = 3;
  // settle counts in oscillator cycles
  localparam int CSO_SETTLE_W = 11;
  localparam logic [10:0] CSO_INTERNAL_SETTLE_3 = 11'h008;
  localparam logic [10:0] CSO_INTERNAL_SETTLE_2 = 11'h010;
  localparam logic [10:0] CSO_INTERNAL_SETTLE_1 = 11'h020;
  localparam logic [10:0] CSO_INTERNAL_SETTLE_0 = 11'h040;
  localparam logic [10:0] CSO_FAST_SETTLE_3 = 11'h080;
  localparam logic [10:0] CSO_FAST_SETTLE_2 = 11'h100;
  localparam logic [10:0] CSO_FAST_SETTLE_1 = 11'h200;
  localparam logic [10:0] CSO_FAST_SETTLE_0 = 11'h400;
  localparam logic [10:0] CSO_LOW_SPEED_SETTLE = 11'h100;
  localparam logic [10:0] CSO_SETTLE_RESET = 11'h000;
endpackage : cso_pkg
`default_nettype wire
